// ===== core/opc_decoder.sv
// opc_decoder: output parameter command decoder with settings store
// assumes AHB-Lite single word transfers; command issued by writing CMD
// Behaviour
// R1 - circle overlay on/off, 1 and 0
// R2 - diameter 0..100 percent, step 1
// R3 - horizontal position -50..+50 percent
// R4 - vertical position -50..+50 percent
// R5 - min, max, default keywords accepted
// R6 - queries return value in force
// R7 - selector 1 signal, 2 black outputs
// R8 - channel 1..16, separate settings each
// R9 - amplitude -60..0 dBFS, 1 dB steps
// R10 - frequency only from fixed list
// R11 - frequency -1 stops channel audio
// R12 - click 0..4, interval in seconds
// R13 - tone muted 0.25 s around click
// R14 - group output on/off, 1 and 0
// R15 - group 1..4 per selector kept
// R16 - emphasis bits only, samples untouched
// R17 - sample width 20 or 24 bits
// R18 - sampling frame, unaligned or free running
// R19 - load named signal by slot
// R20 - report active signal of slot
// R21 - out-of-range argument rejected, value kept
`timescale 1ns/1ps
module opc_decoder #(
  parameter int SEC_CYCLES = opc_pkg::SEC_CYC,
  parameter int MUTE_CYCLES = opc_pkg::MUTE_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // audio channel tone gates, selector 1 in low half
  output logic [31:0] tone_on,
  // group outputs enabled, selector 1 in low nibble
  output logic [7:0] group_on
);
  // ==========================================================
  // bus slave
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] cmd_q, arg_q, resp_q, rdata_q;
  logic [1:0] stat_q;
  logic go;
  logic circ_on_q;
  logic [6:0] diam_q;
  logic signed [6:0] hpos_q, vpos_q;
  logic signed [6:0] ampl_q [32];
  logic [4:0] fidx_q [32];
  logic [2:0] click_q [32];
  logic grp_q [8];
  logic [1:0] emph_q [8];
  logic [4:0] width_q [8];
  logic [1:0] samp_q [8];
  logic [15:0] sig_q [opc_pkg::MOD_SLOTS];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  // latch address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        addr_q <= haddr[7:0];
      end
    end
  end
  // command strobe rises on the same edge that the command word lands in cmd_q,
  // so the decode below already sees the new word
  logic go_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_q && (addr_q == opc_pkg::CMD_OFF);
    end
  end
  assign go = go_q;
  // command and argument registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 32'h0000_0000;
      arg_q <= 32'h0000_0000;
    end else if (wr_q) begin
      if (addr_q == opc_pkg::CMD_OFF) begin
        cmd_q <= hwdata;
      end
      if (addr_q == opc_pkg::ARG_OFF) begin
        arg_q <= hwdata;
      end
    end
  end
  // read data captured in the address phase, so it stands through the data phase;
  // a write still in its own data phase is not yet seen; unmapped reads zero
  logic [31:0] rdata_comb;
  always_comb begin
    rdata_comb = 32'h0000_0000;
    case (haddr[7:0])
      opc_pkg::CMD_OFF: rdata_comb = cmd_q;
      opc_pkg::ARG_OFF: rdata_comb = arg_q;
      opc_pkg::STAT_OFF: rdata_comb = {30'h0, stat_q};
      opc_pkg::RESP_OFF: rdata_comb = resp_q;
      opc_pkg::CIRC_OFF: rdata_comb = {9'h0, circ_on_q, vpos_q, 1'b0, hpos_q, diam_q};
      default: rdata_comb = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      rdata_q <= rdata_comb;
    end
  end
  // ==========================================================
  // command decode
  logic [3:0] op;
  logic qry;
  logic [4:0] ci;
  logic [2:0] gi;
  logic [1:0] kw;
  logic signed [31:0] a;
  logic ok;
  logic [31:0] qv;
  logic [4:0] fhit;
  logic fok;
  assign op = cmd_q[opc_pkg::OP_LSB +: 4];
  assign qry = cmd_q[opc_pkg::QRY_BIT];
  assign ci = {cmd_q[opc_pkg::SEL_BIT], cmd_q[opc_pkg::CH_LSB +: 4]}; // R7 R8
  assign gi = {cmd_q[opc_pkg::SEL_BIT], cmd_q[opc_pkg::GRP_LSB +: 2]}; // R15
  assign kw = cmd_q[opc_pkg::KW_LSB +: 2];
  assign a = $signed(arg_q);
  // frequency list search
  always_comb begin
    fhit = 5'h00;
    fok = 1'b0;
    for (int i = 0; i < opc_pkg::NFREQ; i++) begin
      if (a == opc_pkg::FREQ_LIST[i]) begin
        fhit = 5'(i);
        fok = 1'b1; // R10
      end
    end
  end
  // argument check and query value
  always_comb begin
    ok = 1'b0;
    qv = 32'h0000_0000;
    case (op)
      opc_pkg::OP_CSTATE: begin
        ok = (a == 0) || (a == 1); // R1 R21
        qv = {31'h0, circ_on_q};
      end
      opc_pkg::OP_CDIAM: begin
        ok = (kw != opc_pkg::KW_NUM) || (a >= 0 && a <= opc_pkg::DIAM_MAX); // R2 R5
        qv = {25'h0, diam_q};
      end
      opc_pkg::OP_CHPOS: begin
        ok = (kw != opc_pkg::KW_NUM) || (a >= -opc_pkg::POS_LIM && a <= opc_pkg::POS_LIM); // R3
        qv = 32'(hpos_q);
      end
      opc_pkg::OP_CVPOS: begin
        ok = (kw != opc_pkg::KW_NUM) || (a >= -opc_pkg::POS_LIM && a <= opc_pkg::POS_LIM); // R4
        qv = 32'(vpos_q);
      end
      opc_pkg::OP_AMPL: begin
        ok = a >= opc_pkg::AMPL_MIN && a <= 0; // R9
        qv = 32'(ampl_q[ci]);
      end
      opc_pkg::OP_FREQ: begin
        ok = fok; // R10 R21
        qv = 32'(opc_pkg::FREQ_LIST[fidx_q[ci]]);
      end
      opc_pkg::OP_CLICK: begin
        ok = a >= 0 && a <= opc_pkg::CLICK_MAX; // R12
        qv = {29'h0, click_q[ci]};
      end
      opc_pkg::OP_GSTATE: begin
        ok = (a == 0) || (a == 1); // R14
        qv = {31'h0, grp_q[gi]};
      end
      opc_pkg::OP_EMPH: begin
        ok = a >= 0 && a <= 2; // R16
        qv = {30'h0, emph_q[gi]};
      end
      opc_pkg::OP_WIDTH: begin
        ok = (a == 20) || (a == 24); // R17
        qv = {27'h0, width_q[gi]};
      end
      opc_pkg::OP_SAMPL: begin
        ok = a >= 0 && a <= 2; // R18
        qv = {30'h0, samp_q[gi]};
      end
      opc_pkg::OP_LOAD: begin
        ok = 1'b1; // R19
        qv = 32'h0000_0000;
      end
      opc_pkg::OP_ACTIVE: begin
        ok = 1'b1;
        qv = {16'h0, sig_q[arg_q[3:0]]}; // R20
      end
      default: begin
        ok = 1'b0;
        qv = 32'h0000_0000;
      end
    endcase
  end
  // keyword resolution for circle values
  function automatic logic [6:0] kwv(input logic [1:0] k, input logic [6:0] n,
                                      input int lo, input int hi, input int df);
    case (k)
      opc_pkg::KW_MIN: kwv = 7'(lo);
      opc_pkg::KW_MAX: kwv = 7'(hi);
      opc_pkg::KW_DEF: kwv = 7'(df);
      default: kwv = n;
    endcase
  endfunction : kwv
  // response and status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= opc_pkg::ST_IDLE;
      resp_q <= 32'h0000_0000;
    end else if (go) begin
      stat_q <= (qry || ok) ? opc_pkg::ST_OK : opc_pkg::ST_ERR; // R21
      if (qry || op == opc_pkg::OP_ACTIVE) begin
        resp_q <= qv; // R6
      end
    end
  end
  // circle settings, written only when accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      circ_on_q <= 1'b0;
      diam_q <= 7'(opc_pkg::DIAM_DEF);
      hpos_q <= 7'(opc_pkg::POS_DEF);
      vpos_q <= 7'(opc_pkg::POS_DEF);
    end else if (go && !qry && ok) begin
      case (op)
        opc_pkg::OP_CSTATE: circ_on_q <= arg_q[0]; // R1
        opc_pkg::OP_CDIAM: diam_q <= kwv(kw, arg_q[6:0], 0, opc_pkg::DIAM_MAX,
                                          opc_pkg::DIAM_DEF); // R2 R5
        opc_pkg::OP_CHPOS: hpos_q <= kwv(kw, arg_q[6:0], -opc_pkg::POS_LIM,
                                          opc_pkg::POS_LIM, opc_pkg::POS_DEF); // R3 R5
        opc_pkg::OP_CVPOS: vpos_q <= kwv(kw, arg_q[6:0], -opc_pkg::POS_LIM,
                                          opc_pkg::POS_LIM, opc_pkg::POS_DEF); // R4 R5
        default: circ_on_q <= circ_on_q;
      endcase
    end
  end
  // per channel and per group settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++) begin
        ampl_q[i] <= 7'(opc_pkg::AMPL_DEF);
        fidx_q[i] <= 5'h0D;
        click_q[i] <= 3'h0;
      end
      for (int g = 0; g < 8; g++) begin
        grp_q[g] <= 1'b0;
        emph_q[g] <= opc_pkg::EMPH_OFF;
        width_q[g] <= opc_pkg::WIDTH_24;
        samp_q[g] <= opc_pkg::FRAME_SAMPLING;
      end
    end else if (go && !qry && ok) begin
      case (op)
        opc_pkg::OP_AMPL: ampl_q[ci] <= arg_q[6:0]; // R8 R9
        opc_pkg::OP_FREQ: fidx_q[ci] <= fhit; // R10
        opc_pkg::OP_CLICK: click_q[ci] <= arg_q[2:0]; // R12
        opc_pkg::OP_GSTATE: grp_q[gi] <= arg_q[0]; // R14 R15
        opc_pkg::OP_EMPH: emph_q[gi] <= arg_q[1:0]; // R16
        opc_pkg::OP_WIDTH: width_q[gi] <= arg_q[4:0]; // R17
        opc_pkg::OP_SAMPL: samp_q[gi] <= arg_q[1:0]; // R18
        default: grp_q[gi] <= grp_q[gi];
      endcase
    end
  end
  // loaded signal per module slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int s = 0; s < opc_pkg::MOD_SLOTS; s++) begin
        sig_q[s] <= 16'h0000;
      end
    end else if (go && !qry && op == opc_pkg::OP_LOAD) begin
      sig_q[arg_q[3:0]] <= arg_q[31:16]; // R19
    end
  end
  // ==========================================================
  // click timing: one second tick and seconds counter
  logic [31:0] tick_q;
  logic [3:0] sec_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 32'h0000_0000;
      sec_q <= 4'h0;
    end else if (tick_q == 32'(SEC_CYCLES - 1)) begin
      tick_q <= 32'h0000_0000;
      sec_q <= (sec_q == 4'hB) ? 4'h0 : sec_q + 4'h1;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end
  // mute window centred on each click at the second boundary
  logic near_edge;
  assign near_edge = (tick_q < 32'(MUTE_CYCLES / 2)) ||
                     (tick_q >= 32'(SEC_CYCLES - MUTE_CYCLES / 2)); // R13
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tone_on <= 32'h0000_0000;
      group_on <= 8'h00;
    end else begin
      for (int i = 0; i < 32; i++) begin
        logic [3:0] s;
        logic hit;
        s = (tick_q >= 32'(SEC_CYCLES - MUTE_CYCLES / 2)) ? sec_q + 4'h1 : sec_q;
        hit = (click_q[i] != 3'h0) && near_edge && ((s % 4'(click_q[i])) == 4'h0); // R13
        tone_on[i] <= (fidx_q[i] != 5'h00) && !hit; // R11
      end
      for (int g = 0; g < 8; g++) begin
        group_on[g] <= grp_q[g]; // R14
      end
    end
  end
  // ==========================================================
  // checks
  chk_reject_keeps: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    go && !qry && !ok && op == opc_pkg::OP_CDIAM |=> $stable(diam_q))
    else $error("rejected diameter changed value");
  chk_diam_range: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    diam_q <= 7'(opc_pkg::DIAM_MAX)) else $error("diameter out of range");
  chk_stop_channel: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    fidx_q[0] == 5'h00 |=> !tone_on[0]) else $error("stopped channel still on");
  chk_group_follow: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    go && !qry && ok && op == opc_pkg::OP_GSTATE |=> ##1 group_on[gi] == $past(arg_q[0], 2))
    else $error("group enable not applied");
  chk_width_legal: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    width_q[0] == opc_pkg::WIDTH_20 || width_q[0] == opc_pkg::WIDTH_24)
    else $error("illegal sample width");
  chk_click_mute: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    click_q[0] == 3'h1 && tick_q == 32'h0000_0000 |=> !tone_on[0])
    else $error("tone not muted at click");
  chk_pos_range: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    hpos_q >= -7'sd50 && hpos_q <= 7'sd50) else $error("position out of range");
  chk_query_resp: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    go && qry |=> resp_q == $past(qv)) else $error("query answer wrong");
  chk_vpos_range: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    vpos_q >= -7'sd50 && vpos_q <= 7'sd50) else $error("vertical position out of range");
  chk_ampl_range: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    ampl_q[0] >= -7'sd60 && ampl_q[0] <= 7'sd0) else $error("amplitude out of range");
  chk_click_range: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    click_q[0] <= 3'h4) else $error("click interval out of range");
  chk_emph_legal: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    emph_q[0] != 2'h3) else $error("illegal emphasis code");
  chk_samp_legal: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    samp_q[0] != 2'h3) else $error("illegal sampling code");
  chk_circ_onoff: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    go && !qry && ok && op == opc_pkg::OP_CSTATE |=> circ_on_q == $past(arg_q[0]))
    else $error("circle state not applied");
  chk_load_store: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    go && !qry && op == opc_pkg::OP_LOAD |=> sig_q[$past(arg_q[3:0])] == $past(arg_q[31:16]))
    else $error("loaded signal not stored");
endmodule : opc_decoder

// ===== core/opc_pkg.sv
// opc_pkg: constants for the output parameter command decoder
// assumes a 32-bit AHB-Lite register slave in front of the decoder
package opc_pkg;
  // register byte offsets
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] ARG_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] RESP_OFF = 8'h0C;
  localparam logic [7:0] SIG_OFF = 8'h10;
  localparam logic [7:0] CIRC_OFF = 8'h14;
  // command word fields: [3:0] opcode, [4] query, [5] output sel-1,
  // [9:6] channel-1, [11:10] group-1, [13:12] keyword
  localparam int OP_LSB = 0;
  localparam int QRY_BIT = 4;
  localparam int SEL_BIT = 5;
  localparam int CH_LSB = 6;
  localparam int GRP_LSB = 10;
  localparam int KW_LSB = 12;
  // opcodes
  localparam logic [3:0] OP_CSTATE = 4'h0;
  localparam logic [3:0] OP_CDIAM = 4'h1;
  localparam logic [3:0] OP_CHPOS = 4'h2;
  localparam logic [3:0] OP_CVPOS = 4'h3;
  localparam logic [3:0] OP_AMPL = 4'h4;
  localparam logic [3:0] OP_FREQ = 4'h5;
  localparam logic [3:0] OP_CLICK = 4'h6;
  localparam logic [3:0] OP_GSTATE = 4'h7;
  localparam logic [3:0] OP_EMPH = 4'h8;
  localparam logic [3:0] OP_WIDTH = 4'h9;
  localparam logic [3:0] OP_SAMPL = 4'hA;
  localparam logic [3:0] OP_LOAD = 4'hB;
  localparam logic [3:0] OP_ACTIVE = 4'hC;
  // keywords replacing a number
  localparam logic [1:0] KW_NUM = 2'h0;
  localparam logic [1:0] KW_MIN = 2'h1;
  localparam logic [1:0] KW_MAX = 2'h2;
  localparam logic [1:0] KW_DEF = 2'h3;
  // limits and defaults
  localparam int DIAM_MAX = 100;
  localparam int DIAM_DEF = 90;
  localparam int POS_LIM = 50;
  localparam int POS_DEF = 0;
  localparam int AMPL_MIN = -60;
  localparam int AMPL_DEF = -20;
  localparam int FREQ_DEF = 1000;
  localparam int CLICK_MAX = 4;
  localparam int MOD_SLOTS = 16;
  // emphasis, width and sampling codes
  localparam logic [1:0] EMPH_OFF = 2'h0;
  localparam logic [1:0] EMPH_CD = 2'h1;
  localparam logic [1:0] TELEPHONY_EMPHASIS = 2'h2;
  localparam logic [1:0] FRAME_SAMPLING = 2'h0;
  localparam logic [1:0] UNALIGNED_SAMPLING = 2'h1;
  localparam logic [1:0] FREE_RUNNING_SAMPLING = 2'h2;
  localparam logic [4:0] WIDTH_20 = 5'h14;
  localparam logic [4:0] WIDTH_24 = 5'h18;
  // response status codes
  localparam logic [1:0] ST_IDLE = 2'h0;
  localparam logic [1:0] ST_OK = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;
  // allowed tone frequencies, -1 stops the channel
  localparam int NFREQ = 32;
  localparam int FREQ_LIST [NFREQ] = '{-1, 0, 50, 100, 150, 200, 250, 300, 400, 500,
    600, 750, 800, 1000, 1200, 1500, 1600, 2000, 2400, 3000, 3200, 4000, 4800, 5000,
    6000, 8000, 9600, 10000, 12000, 15000, 16000, 20000};
  // click mute window
  localparam real MUTE_S = 0.25;
  localparam real CLK_HZ = 200.0e6;
  localparam int SEC_CYC = 200000000;
  localparam int MUTE_CYC = int'(MUTE_S * CLK_HZ);
endpackage : opc_pkg

// ===== verification/opc_decoder_tb.sv
// opc_decoder_tb: random and directed commands checked against an int model
// assumes opc_host as bus master and zero-wait slave answers
`timescale 1ns/1ps
module opc_decoder_tb;
  localparam int SECS = 100;
  localparam int MUTE = 24;
  localparam int BT [26][2] = '{'{0,1},'{0,2},'{1,100},'{1,101},'{2,-50},'{2,-51},
    '{3,50},'{3,51},'{4,0},'{4,1},'{4,-60},'{4,-61},'{5,-1},'{5,20000},'{5,20001},
    '{6,4},'{6,5},'{6,0},'{7,1},'{7,2},'{8,2},'{8,3},'{9,20},'{9,25},'{10,2},'{10,3}};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, tone_on, rd;
  logic [7:0] group_on;
  int bad_count = 0;
  int cmp_count = 0;
  int cs [4] = '{0, 90, 0, 0};
  int am [2][16] = '{default: -20};
  int fr [2][16] = '{default: 1000};
  int ck [2][16] = '{default: 0};
  int gon [2][4] = '{default: 0};
  int em [2][4] = '{default: 0};
  int wd [2][4] = '{default: 24};
  int sa [2][4] = '{default: 0};
  int sg [16] = '{default: 0};
  int op, a, cnt;

  // ==========================================================
  // clock, dut and master
  always #2.5 hclk = ~hclk;

  opc_decoder #(.SEC_CYCLES(SECS), .MUTE_CYCLES(MUTE)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .tone_on(tone_on), .group_on(group_on));
  opc_host i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  // ==========================================================
  // model and checks
  // apply a setting, returns whether it is accepted
  function automatic bit mdl_set(input int op, s, c, g, kw, a);
    int v;
    v = a;
    if (op >= 1 && op <= 3 && kw != 0) begin
      v = (op == 1) ? ((kw == 1) ? 0 : (kw == 2) ? 100 : 90) : ((kw == 1) ? -50 : (kw == 2) ? 50 : 0);
    end
    case (op)
      0, 7: mdl_set = v == 0 || v == 1;
      1: mdl_set = v >= 0 && v <= 100;
      2, 3: mdl_set = v >= -50 && v <= 50;
      4: mdl_set = v >= -60 && v <= 0;
      5: begin
        mdl_set = 1'b0;
        for (int i = 0; i < opc_pkg::NFREQ; i++) mdl_set |= opc_pkg::FREQ_LIST[i] == v;
      end
      6: mdl_set = v >= 0 && v <= 4;
      8, 10: mdl_set = v >= 0 && v <= 2;
      9: mdl_set = v == 20 || v == 24;
      default: mdl_set = 1'b1;
    endcase
    if (mdl_set) begin
      case (op)
        0, 1, 2, 3: cs[op] = v;
        4: am[s][c] = v;
        5: fr[s][c] = v;
        6: ck[s][c] = v;
        7: gon[s][g] = v;
        8: em[s][g] = v;
        9: wd[s][g] = v;
        10: sa[s][g] = v;
        default: sg[v & 15] = (v >> 16) & 16'hFFFF;
      endcase
    end
  endfunction : mdl_set

  // value in force for a query
  function automatic int mdl_q(input int op, s, c, g, a);
    case (op)
      0, 1, 2, 3: mdl_q = cs[op];
      4: mdl_q = am[s][c];
      5: mdl_q = fr[s][c];
      6: mdl_q = ck[s][c];
      7: mdl_q = gon[s][g];
      8: mdl_q = em[s][g];
      9: mdl_q = wd[s][g];
      10: mdl_q = sa[s][g];
      default: mdl_q = sg[a & 15];
    endcase
  endfunction : mdl_q

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  // tone gates and group outputs, clicking channels masked
  task automatic chk_pins();
    logic [31:0] t, m;
    logic [7:0] gv;
    for (int i = 0; i < 32; i++) begin
      t[i] = fr[i / 16][i % 16] != -1 && ck[i / 16][i % 16] == 0;
      m[i] = ck[i / 16][i % 16] != 0;
    end
    for (int i = 0; i < 8; i++) gv[i] = gon[i / 4][i % 4] != 0;
    chk_word("tone gates", t, tone_on & ~m);
    chk_word("group outputs", {24'h0, gv}, {24'h0, group_on});
  endtask : chk_pins

  // argument, command, then status or answer
  task automatic do_cmd(input int op, q, s, c, g, kw, a);
    logic [31:0] w, r;
    w = 32'(op) | (32'(q) << 4) | (32'(s) << 5) | (32'(c) << 6) | (32'(g) << 10);
    w = w | (32'(kw) << 12);
    i_host.xfer(1'b1, 32'(opc_pkg::ARG_OFF), 32'(a), r);
    i_host.xfer(1'b1, 32'(opc_pkg::CMD_OFF), w, r);
    repeat (2) @(posedge hclk);
    if (q != 0) begin
      i_host.xfer(1'b0, 32'(opc_pkg::RESP_OFF), 32'h0, r);
      chk_word("query answer", 32'(mdl_q(op, s, c, g, a)), r);
    end else begin
      w = mdl_set(op, s, c, g, kw, a) ? 32'(opc_pkg::ST_OK) : 32'(opc_pkg::ST_ERR);
      i_host.xfer(1'b0, 32'(opc_pkg::STAT_OFF), 32'h0, r);
      chk_word("status", w, r);
    end
    chk_word("response code", 32'h0, {31'h0, hresp});
    chk_pins();
  endtask : do_cmd

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // tests
  // main sequence
  initial begin
    void'($urandom(82412));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int o = 0; o <= 10; o++) do_cmd(o, 1, 1, 15, 3, 0, 0);
    $display("test defaults done");
    foreach (BT[i]) begin
      do_cmd(BT[i][0], 0, 0, 0, 0, 0, BT[i][1]);
      do_cmd(BT[i][0], 1, 0, 0, 0, 0, 0);
    end
    $display("test boundaries done");
    for (int o = 1; o <= 3; o++) begin
      for (int k = 1; k <= 3; k++) begin
        do_cmd(o, 0, 0, 0, 0, k, 77);
        do_cmd(o, 1, 0, 0, 0, 0, 0);
      end
    end
    $display("test keywords done");
    repeat (80) begin
      op = $urandom_range(0, 10);
      if (op == 6) op = 4;
      a = int'($urandom_range(0, 130)) - 70;
      if (op == 5) a = ($urandom_range(0, 3) == 0) ? 7 : opc_pkg::FREQ_LIST[$urandom_range(0, 31)];
      if (op == 9) a = 20 + int'($urandom_range(0, 4));
      cnt = $urandom_range(0, 63);
      do_cmd(op, 0, cnt & 1, cnt >> 2, cnt & 3, 0, a);
      do_cmd(op, 1, cnt & 1, cnt >> 2, cnt & 3, 0, 0);
    end
    i_host.xfer(1'b0, 32'(opc_pkg::CIRC_OFF), 32'h0, rd);
    chk_word("circle word", {9'h0, 1'(cs[0]), 7'(cs[3]), 1'b0, 7'(cs[2]), 7'(cs[1])}, rd);
    i_host.xfer(1'b0, 32'h18, 32'h0, rd);
    chk_word("unmapped read", 32'h0, rd);
    $display("test random done");
    for (int i = 0; i < 4; i++) begin
      a = int'($urandom_range(0, 32767)) << 16 | int'($urandom_range(0, 15));
      do_cmd(11, 0, 0, 0, 0, 0, a);
      do_cmd(12, 1, 0, 0, 0, 0, a & 15);
    end
    $display("test signal load done");
    do_cmd(5, 0, 0, 0, 0, 0, 1000);
    for (int n = 1; n <= 4; n += 3) begin
      do_cmd(6, 0, 0, 0, 0, 0, n);
      cnt = 0;
      repeat (12 * SECS) begin
        @(posedge hclk);
        cnt += (tone_on[0] === 1'b0);
      end
      chk_word("muted cycles", 32'((12 / n) * MUTE), 32'(cnt));
    end
    do_cmd(6, 0, 0, 0, 0, 0, 0);
    $display("test click done");
    test_done();
  end

  // watchdog against a hung bus
  initial begin
    repeat (30000) @(posedge hclk);
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule : opc_decoder_tb

// ===== verification/opc_host.sv
// opc_host: ahb-lite master standing in for the remote controller
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module opc_host (
  // clock
  input wire logic hclk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ==========================================================
  // bus cycles
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // one single word transfer, address then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    hwdata <= ~wd; // released data never shows the old word
  endtask : xfer
endmodule : opc_host
